//--- include/motor_pwm_pkg.sv
// Constants, register map and field layouts of the motor PWM and channel manager.
// Assumes a 100 MHz system clock and an 8-bit AXI4-Lite byte address.
package motor_pwm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Commutation timer: 255 ticks span the longest step period of code zero.
  localparam int unsigned STEP_PERIOD_MAX_CODE0_NS = 127_500;
  localparam int unsigned STEP_PERIOD_MIN_CODE0_NS = 42_500;
  localparam int unsigned TIMER_FULL_COUNT = 255;
  localparam int unsigned TIMER_TICK_CYC =
    STEP_PERIOD_MAX_CODE0_NS / TIMER_FULL_COUNT / CLK_PERIOD_NS;

  // Window off times (least times, rounded up).
  localparam int unsigned OFF_TIME_NS [4] = '{5_000, 10_000, 15_000, 30_000};
  localparam int unsigned OFF_TIME_HALL_NS = 1_250;
  localparam int unsigned FILTER_TIME_NS = 2_500;
  localparam int unsigned FILTER_CYC = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_HALL_CYC = (OFF_TIME_HALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Measurement window frequencies per rate code, in Hz.
  localparam real WINDOW_FREQ_HZ [16] = '{
    25_000.0, 20_000.0, 18_100.0, 15_400.0, 12_500.0, 10_000.0, 6_250.0, 3_130.0,
    1_560.0, 1_250.0, 1_140.0, 961.0, 781.0, 625.0, 390.0, 195.0};
  typedef int unsigned period_table_t [16];

  function automatic period_table_t window_period_cycles();
    period_table_t t;
    for (int i = 0; i < 16; i++) begin
      t[i] = int'($floor(real'(CLK_FREQ_HZ) / WINDOW_FREQ_HZ[i]));
    end
    return t;
  endfunction

  localparam period_table_t WINDOW_PERIOD_CYC_DEFAULT = window_period_cycles();

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
  localparam logic [7:0] ADDR_PRESCALER_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_POLARITY = 8'h0c;
  localparam logic [7:0] ADDR_PHASE_PRELOAD = 8'h10;
  localparam logic [7:0] ADDR_GROUP = 8'h14;
  localparam logic [7:0] ADDR_TIMER = 8'h18;
  localparam logic [7:0] ADDR_PRIOR_CAPTURE = 8'h1c;
  localparam logic [7:0] ADDR_CURRENT_CAPTURE = 8'h20;
  localparam logic [7:0] ADDR_COMPARE = 8'h24;
  localparam logic [7:0] ADDR_DEMAG = 8'h28;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field layouts, least significant field last.
  typedef struct packed {
    logic emergency_irq_mask;
    logic hall_sensor_mode;
    logic voltage_current_sel;
    logic auto_commutation_sel;
    logic output_enable_main;
  } control_a_s;

  typedef struct packed {
    logic pwm_route_odd;
    logic pwm_route_even;
    logic comparator_filter_en;
  } control_b_s;

  typedef struct packed {
    logic emergency_flag;
    logic ratio_down_flag;
    logic ratio_up_flag;
  } irq_flags_s;

  localparam control_a_s CONTROL_A_RESET = '0;
  localparam control_b_s CONTROL_B_RESET = '0;
  localparam irq_flags_s IRQ_FLAGS_RESET = '0;
  localparam logic [7:0] TIMER_REG_RESET = 8'h00;
  localparam logic [5:0] CHANNEL_RESET = 6'h00;

  localparam logic [7:0] TIMER_MAX = 8'hff;
  localparam logic [7:0] TIMER_SPEEDUP_LIMIT = 8'h55;
  localparam logic [3:0] CODE_MAX = 4'hf;
  localparam logic [3:0] CODE_MIN = 4'h0;

  typedef enum logic [1:0] {
    MODE_CONFIG,
    MODE_SWITCHED,
    MODE_AUTO
  } mode_e;

endpackage

//--- verilog/window_generator.sv
// Measurement window generator: a free-running period counter whose first
// off_cyc cycles form the window. Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module window_generator
  import motor_pwm_pkg::*;
#(
  parameter period_table_t PERIOD_CYC = WINDOW_PERIOD_CYC_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] rate_sel,
  input wire logic [11:0] off_cyc,
  output logic meas_window,
  output logic window_begin,
  output logic window_end
);

  logic [19:0] period_cnt_reg;
  logic [19:0] period_last;
  logic window_next;

  assign period_last = 20'(PERIOD_CYC[rate_sel] - 1);
  assign window_next = (period_cnt_reg < 20'(off_cyc));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      period_cnt_reg <= '0;
    end else if (period_cnt_reg >= period_last) begin
      period_cnt_reg <= '0;
    end else begin
      period_cnt_reg <= period_cnt_reg + 20'h1;
    end
  end

  // Edges are registered together with the level so they line up with it.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meas_window <= 1'b0;
      window_begin <= 1'b0;
      window_end <= 1'b0;
    end else begin
      meas_window <= window_next;
      window_begin <= window_next & ~meas_window;
      window_end <= ~window_next & meas_window;
    end
  end

endmodule // window_generator

//--- verilog/motor_pwm_channel_manager.sv
// PWM manager and six-channel output manager of a brushless motor controller,
// with the commutation timer prescaler and its access modes.
// Assumes a 100 MHz clock, synchronous inputs and an AXI4-Lite master.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module motor_pwm_channel_manager
  import motor_pwm_pkg::*;
#(
  parameter period_table_t WINDOW_PERIOD_CYC = WINDOW_PERIOD_CYC_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_a_pwm,
  input wire logic current_level_reached,
  input wire logic commutation_event,
  input wire logic zero_crossing_event,
  input wire logic emergency_halt_n,
  output logic [5:0] motor_drive_outputs,
  output logic [5:0] motor_drive_oe_n,
  output logic bemf_sample_enable,
  output logic emergency_irq_req
);

  // ****************************************
  // Register state
  // ****************************************
  control_a_s control_a_reg;
  control_b_s control_b_reg;
  irq_flags_s irq_flags_reg;
  logic [3:0] speed_prescaler_code;
  logic [3:0] window_rate_sel;
  logic [5:0] channel_polarity_bits;
  logic [1:0] window_width_sel;
  logic [5:0] channel_active_bits;
  logic [5:0] channel_group_sel;
  logic [5:0] phase_reg;
  logic [7:0] commutation_timer;
  logic [7:0] prior_crossing_capture;
  logic [7:0] current_crossing_capture;
  logic [7:0] next_commutation_compare;
  logic [7:0] demag_compare;
  mode_e mode;
  logic emergency_halt_n_reg;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] waddr_reg;
  logic [7:0] wdata_reg;
  logic wlane_reg;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rdata_next;
  logic rd_ok;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    unique case (waddr_reg)
      ADDR_CONTROL_A, ADDR_CONTROL_B, ADDR_PRESCALER_WINDOW, ADDR_POLARITY,
      ADDR_PHASE_PRELOAD, ADDR_GROUP, ADDR_TIMER, ADDR_PRIOR_CAPTURE,
      ADDR_CURRENT_CAPTURE, ADDR_COMPARE, ADDR_DEMAG, ADDR_IRQ_FLAGS,
      ADDR_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wlane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register data; other lanes are ignored.
  function automatic logic wr_hit(input logic [7:0] addr);
    return wr_fire & wlane_reg & (waddr_reg == addr);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Access mode and register writes
  // ****************************************
  always_comb begin
    if (!control_a_reg.output_enable_main) begin
      mode = MODE_CONFIG;
    end else if (control_a_reg.auto_commutation_sel) begin
      mode = MODE_AUTO;
    end else begin
      mode = MODE_SWITCHED;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_a_reg <= CONTROL_A_RESET;
      emergency_halt_n_reg <= 1'b1;
    end else begin
      emergency_halt_n_reg <= emergency_halt_n;
      if (wr_hit(ADDR_CONTROL_A)) begin
        control_a_reg <= control_a_s'(wdata_reg[4:0]);
      end
      if (!emergency_halt_n) begin
        control_a_reg.output_enable_main <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_b_reg <= CONTROL_B_RESET;
      window_rate_sel <= '0;
      channel_polarity_bits <= CHANNEL_RESET;
      window_width_sel <= '0;
      channel_active_bits <= CHANNEL_RESET;
      channel_group_sel <= CHANNEL_RESET;
    end else begin
      if (wr_hit(ADDR_CONTROL_B)) begin
        control_b_reg <= control_b_s'(wdata_reg[2:0]);
      end
      if (wr_hit(ADDR_PRESCALER_WINDOW)) begin
        window_rate_sel <= wdata_reg[7:4];
      end
      if (wr_hit(ADDR_POLARITY)) begin
        channel_polarity_bits <= wdata_reg[5:0];
        window_width_sel <= wdata_reg[7:6];
      end
      if (wr_hit(ADDR_PHASE_PRELOAD)) begin
        channel_active_bits <= wdata_reg[5:0];
      end
      if (wr_hit(ADDR_GROUP)) begin
        channel_group_sel <= wdata_reg[5:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_reg <= CHANNEL_RESET;
    end else if (commutation_event) begin
      phase_reg <= channel_active_bits;
    end
  end

  // ****************************************
  // Commutation timer and prescaler
  // ****************************************
  logic [23:0] presc_cnt_reg;
  logic [23:0] presc_last;
  logic timer_tick;
  logic timer_running;

  // The tick period doubles with each code step.
  assign presc_last = (24'(TIMER_TICK_CYC) << speed_prescaler_code) - 24'h1;
  assign timer_running = (mode != MODE_CONFIG);
  assign timer_tick = timer_running & (presc_cnt_reg >= presc_last);

  always_ff @(posedge clk_sys) begin
    if (reset || !timer_running || timer_tick) begin
      presc_cnt_reg <= '0;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 24'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      commutation_timer <= TIMER_REG_RESET;
      prior_crossing_capture <= TIMER_REG_RESET;
      current_crossing_capture <= TIMER_REG_RESET;
      next_commutation_compare <= TIMER_REG_RESET;
      demag_compare <= TIMER_REG_RESET;
      speed_prescaler_code <= CODE_MIN;
      irq_flags_reg <= IRQ_FLAGS_RESET;
    end else begin
      // Software clears come first so that a hardware set in the same cycle wins.
      if (wr_hit(ADDR_IRQ_FLAGS)) begin
        if (wdata_reg[2]) begin
          irq_flags_reg.emergency_flag <= 1'b0;
        end
        if (mode == MODE_AUTO) begin
          if (wdata_reg[0]) begin
            irq_flags_reg.ratio_up_flag <= 1'b0;
          end
          if (wdata_reg[1]) begin
            irq_flags_reg.ratio_down_flag <= 1'b0;
          end
        end else if (mode == MODE_SWITCHED) begin
          if (wdata_reg[0] && speed_prescaler_code != CODE_MAX) begin
            speed_prescaler_code <= speed_prescaler_code + 4'h1;
          end else if (wdata_reg[1] && speed_prescaler_code != CODE_MIN) begin
            speed_prescaler_code <= speed_prescaler_code - 4'h1;
          end
        end
      end
      if (timer_running && zero_crossing_event) begin
        commutation_timer <= '0;
        if (mode == MODE_AUTO && commutation_timer < TIMER_SPEEDUP_LIMIT
            && speed_prescaler_code != CODE_MIN) begin
          speed_prescaler_code <= speed_prescaler_code - 4'h1;
          current_crossing_capture <= {commutation_timer[6:0], 1'b0};
          prior_crossing_capture <= {current_crossing_capture[6:0], 1'b0};
          next_commutation_compare <= {next_commutation_compare[6:0], 1'b0};
          demag_compare <= {demag_compare[6:0], 1'b0};
          irq_flags_reg.ratio_down_flag <= 1'b1;
        end else begin
          current_crossing_capture <= commutation_timer;
          prior_crossing_capture <= current_crossing_capture;
        end
      end else if (timer_tick) begin
        if (commutation_timer != TIMER_MAX) begin
          commutation_timer <= commutation_timer + 8'h1;
        end else if (mode == MODE_AUTO && speed_prescaler_code != CODE_MAX) begin
          // At the top code the timer simply sticks at its maximum.
          speed_prescaler_code <= speed_prescaler_code + 4'h1;
          commutation_timer <= TIMER_MAX >> 1;
          current_crossing_capture <= current_crossing_capture >> 1;
          prior_crossing_capture <= prior_crossing_capture >> 1;
          next_commutation_compare <= next_commutation_compare >> 1;
          demag_compare <= demag_compare >> 1;
          irq_flags_reg.ratio_up_flag <= 1'b1;
        end
      end
      if (mode == MODE_CONFIG) begin
        if (wr_hit(ADDR_TIMER)) commutation_timer <= wdata_reg;
        if (wr_hit(ADDR_PRIOR_CAPTURE)) prior_crossing_capture <= wdata_reg;
        if (wr_hit(ADDR_CURRENT_CAPTURE)) current_crossing_capture <= wdata_reg;
        if (wr_hit(ADDR_PRESCALER_WINDOW)) speed_prescaler_code <= wdata_reg[3:0];
      end
      if (wr_hit(ADDR_COMPARE) && mode != MODE_AUTO) begin
        next_commutation_compare <= wdata_reg;
      end
      if (wr_hit(ADDR_DEMAG)) begin
        demag_compare <= wdata_reg;
      end
      if (emergency_halt_n_reg && !emergency_halt_n) begin
        irq_flags_reg.emergency_flag <= 1'b1;
      end
    end
  end

  // ****************************************
  // Measurement window and comparator filter
  // ****************************************
  logic [11:0] off_cyc;
  logic meas_window;
  logic window_begin;
  logic window_end;
  logic [11:0] filter_cnt_reg;
  logic trip_filtered;

  always_comb begin
    if (control_a_reg.hall_sensor_mode) begin
      off_cyc = 12'(OFF_HALL_CYC);
    end else begin
      off_cyc = 12'((OFF_TIME_NS[window_width_sel] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    end
  end

  window_generator #(
    .PERIOD_CYC(WINDOW_PERIOD_CYC)
  ) u_window (
    .clk_sys(clk_sys),
    .reset(reset),
    .rate_sel(window_rate_sel),
    .off_cyc(off_cyc),
    .meas_window(meas_window),
    .window_begin(window_begin),
    .window_end(window_end)
  );

  // Trip only after the comparator has stayed high for the whole filter time.
  always_ff @(posedge clk_sys) begin
    if (reset || !current_level_reached) begin
      filter_cnt_reg <= '0;
    end else if (filter_cnt_reg != 12'(FILTER_CYC)) begin
      filter_cnt_reg <= filter_cnt_reg + 12'h1;
    end
  end

  assign trip_filtered = control_b_reg.comparator_filter_en ?
    (filter_cnt_reg == 12'(FILTER_CYC)) : current_level_reached;

  // ****************************************
  // PWM manager
  // ****************************************
  logic pwm_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwm_reg <= 1'b0;
    end else if (!control_a_reg.voltage_current_sel) begin
      // The comparator only limits current here; the reference is external.
      pwm_reg <= timer_a_pwm & ~trip_filtered;
    end else if (trip_filtered || window_begin) begin
      pwm_reg <= 1'b0;
    end else if (window_end) begin
      pwm_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bemf_sample_enable <= 1'b0;
    end else if (control_a_reg.hall_sensor_mode) begin
      bemf_sample_enable <= 1'b0;
    end else if (!control_a_reg.voltage_current_sel) begin
      bemf_sample_enable <= ~pwm_reg;
    end else begin
      bemf_sample_enable <= meas_window;
    end
  end

  // ****************************************
  // Channel manager
  // ****************************************
  logic [5:0] drive_next;

  for (genvar ch = 0; ch < 6; ch++) begin : g_channel
    logic pwm_allowed;
    logic switch_on;
    assign pwm_allowed = channel_group_sel[ch] ?
      control_b_reg.pwm_route_odd : control_b_reg.pwm_route_even;
    assign switch_on = phase_reg[ch] & (pwm_reg | ~pwm_allowed);
    assign drive_next[ch] = switch_on ^ ~channel_polarity_bits[ch];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      motor_drive_outputs <= ~CHANNEL_RESET;
      emergency_irq_req <= 1'b0;
    end else begin
      motor_drive_outputs <= drive_next;
      emergency_irq_req <= irq_flags_reg.emergency_flag & control_a_reg.emergency_irq_mask;
    end
  end

  // The pin reaches the buffers without passing any flip-flop.
  assign motor_drive_oe_n = {6{~(emergency_halt_n & control_a_reg.output_enable_main)}};

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdata_next = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CONTROL_A: rdata_next[4:0] = control_a_reg;
      ADDR_CONTROL_B: rdata_next[2:0] = control_b_reg;
      ADDR_PRESCALER_WINDOW: rdata_next[7:0] = {window_rate_sel, speed_prescaler_code};
      ADDR_POLARITY: rdata_next[7:0] = {window_width_sel, channel_polarity_bits};
      ADDR_PHASE_PRELOAD: rdata_next[5:0] = channel_active_bits;
      ADDR_GROUP: rdata_next[5:0] = channel_group_sel;
      ADDR_TIMER: rdata_next[7:0] = commutation_timer;
      ADDR_PRIOR_CAPTURE: rdata_next[7:0] = prior_crossing_capture;
      ADDR_CURRENT_CAPTURE: rdata_next[7:0] = current_crossing_capture;
      ADDR_COMPARE: rdata_next[7:0] = next_commutation_compare;
      ADDR_DEMAG: rdata_next[7:0] = demag_compare;
      ADDR_IRQ_FLAGS: rdata_next[2:0] = irq_flags_reg;
      ADDR_STATUS: rdata_next[8:0] = {trip_filtered, meas_window, pwm_reg, phase_reg};
      default: rd_ok = 1'b0;
    endcase
  end

endmodule // motor_pwm_channel_manager

//--- test/motor_pwm_checker.sv
// Port-level assertions for the motor PWM channel manager.
// Assumes one clock, clk_sys, and a synchronous active-high reset.
`timescale 1ns/1ps
module motor_pwm_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic emergency_halt_n,
  input wire logic [5:0] motor_drive_outputs,
  input wire logic [5:0] motor_drive_oe_n
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_oe_emerg; !emergency_halt_n |-> motor_drive_oe_n == 6'h3f; endproperty
  property p_oe_same; motor_drive_oe_n == 6'h00 || motor_drive_oe_n == 6'h3f; endproperty
  property p_halt_clear; $rose(emergency_halt_n) |-> motor_drive_oe_n == 6'h3f; endproperty
  property p_oe_on; $fell(motor_drive_oe_n[0]) |-> $rose(s_axi_bvalid); endproperty
  property p_rst_out; $fell(reset) |-> motor_drive_outputs == 6'h3f; endproperty
  property p_wr_answer; s_taken |-> ##[1:2] s_axi_bvalid; endproperty
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_oe_emerg: assert property (p_oe_emerg) else $error("outputs driven in emergency");
  a_oe_same: assert property (p_oe_same) else $error("output enables differ");
  a_halt_clear: assert property (p_halt_clear) else $error("enable kept");
  a_oe_on: assert property (p_oe_on) else $error("enable without write");
  a_rst_out: assert property (p_rst_out) else $error("bad reset outputs");
  a_wr_answer: assert property (p_wr_answer) else $error("no write response");
  a_b_block: assert property (p_b_block) else $error("write taken early");
  a_rd_answer: assert property (p_rd_answer) else $error("no read response");
endmodule // motor_pwm_checker
bind motor_pwm_channel_manager motor_pwm_checker motor_pwm_checker_i (.clk_sys(clk_sys),
  .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .emergency_halt_n(emergency_halt_n), .motor_drive_outputs(motor_drive_outputs),
  .motor_drive_oe_n(motor_drive_oe_n));

//--- test/motor_power_stage_model.sv
// Power switch drivers and current sense of the motor.
// Assumes the drivers' inputs are pulled low when released.
`timescale 1ns/1ps
module motor_power_stage_model (
  input wire logic [5:0] motor_drive_outputs,
  input wire logic [5:0] motor_drive_oe_n,
  input wire logic trip_cmd,
  output logic [5:0] gate_level,
  output logic current_level_reached
);
  assign gate_level = motor_drive_outputs & ~motor_drive_oe_n;
  // The limit reference is always wired, so the comparator answers on command.
  assign current_level_reached = trip_cmd;
endmodule // motor_power_stage_model

//--- test/test_motor_pwm_channel_manager.sv
// Self-checking bench of the motor PWM channel manager.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module test_motor_pwm_channel_manager import motor_pwm_pkg::*;;
  logic clk_sys, reset, awvalid, wvalid, bready, arvalid, rready, tpwm, cur, cev, halt_n;
  logic awready, wready, bvalid, arready, rvalid, irq, trip, zc, bemf;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] outs, oe_n, gate;
  int bad_count, cmp_count;
  motor_pwm_channel_manager #(.WINDOW_PERIOD_CYC('{default: 1000})) motor_pwm_channel_manager_i (
    .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_a_pwm(tpwm), .current_level_reached(cur), .commutation_event(cev),
    .zero_crossing_event(zc), .emergency_halt_n(halt_n), .motor_drive_outputs(outs),
    .motor_drive_oe_n(oe_n), .bemf_sample_enable(bemf), .emergency_irq_req(irq));
  motor_power_stage_model motor_power_stage_model_i (.motor_drive_outputs(outs),
    .motor_drive_oe_n(oe_n), .trip_cmd(trip), .gate_level(gate), .current_level_reached(cur));
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Ready is read at the falling edge, so the value is the one the next rising edge sees.
  task axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = awready;
      tw = wready;
      tb = bvalid;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tb;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = arready;
      tb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
    end while (!tb);
    rready <= 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_access;
    axi_wr(ADDR_PRESCALER_WINDOW, 8'h05);
    axi_wr(ADDR_COMPARE, 8'h11);
    axi_wr(ADDR_CONTROL_A, 8'h01);
    axi_wr(ADDR_IRQ_FLAGS, 8'h01);
    axi_rd(ADDR_PRESCALER_WINDOW, v, rs);
    chk(v, 32'h06);
    axi_wr(ADDR_CONTROL_A, 8'h03);
    axi_wr(ADDR_COMPARE, 8'h22);
    axi_rd(ADDR_COMPARE, v, rs);
    chk(v, 32'h11);
    axi_rd(8'h3c, v, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    @(posedge clk_sys) zc <= 1'b1;
    @(posedge clk_sys) zc <= 1'b0;
    axi_rd(ADDR_PRESCALER_WINDOW, v, rs);
    chk(v, 32'h05);
    axi_rd(ADDR_IRQ_FLAGS, v, rs);
    chk(v, 32'h02);
    axi_wr(ADDR_CONTROL_A, 8'h00);
  endtask
  task t_channel;
    axi_wr(ADDR_POLARITY, 8'h0f);
    axi_wr(ADDR_PHASE_PRELOAD, 8'h03);
    settle(2);
    chk(32'(outs), 32'h30);
    @(posedge clk_sys) cev <= 1'b1;
    @(posedge clk_sys) cev <= 1'b0;
    settle(2);
    chk(32'(outs), 32'h33);
  endtask
  task t_route;
    axi_wr(ADDR_GROUP, 8'h3f);
    axi_wr(ADDR_CONTROL_B, 8'h04);
    settle(3);
    chk(32'(outs), 32'h30);
    @(posedge clk_sys) tpwm <= 1'b1;
    settle(3);
    chk(32'(outs), 32'h33);
    chk(32'(bemf), 32'h0);
    axi_wr(ADDR_GROUP, 8'h00);
    tpwm <= 1'b0;
    settle(3);
    chk(32'(outs), 32'h33);
  endtask
  task t_emerg;
    axi_wr(ADDR_CONTROL_A, 8'h11);
    settle(1);
    chk(32'(oe_n), 32'h00);
    @(posedge clk_sys) halt_n <= 1'b0;
    #1;
    chk(32'(oe_n), 32'h3f);
    chk(32'(gate), 32'h00);
    settle(4);
    chk(32'(irq), 32'h1);
    @(posedge clk_sys) halt_n <= 1'b1;
    axi_rd(ADDR_CONTROL_A, v, rs);
    chk(v, 32'h10);
  endtask
  task t_current;
    axi_wr(ADDR_CONTROL_A, 8'h04);
    do @(negedge clk_sys); while (!bemf);
    do @(negedge clk_sys); while (bemf);
    axi_rd(ADDR_STATUS, v, rs);
    chk(v[6], 1'b1);
    trip <= 1'b1;
    axi_rd(ADDR_STATUS, v, rs);
    chk(v[6], 1'b0);
  endtask
  task print_verdict;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, tpwm, cev, trip, zc} = '0;
    {awaddr, araddr, wdata} = '0;
    reset = 1'b1;
    halt_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    settle(1);
    chk(32'(outs), 32'h3f);
    chk(32'(oe_n), 32'h3f);
    t_access;
    t_channel;
    t_route;
    t_emerg;
    t_current;
    print_verdict;
  end
endmodule // test_motor_pwm_channel_manager
